/* File: hdl/fecs_consts.svh */
/*
 * constants of the flash erase command sequencer: flash command bytes,
 * status bit positions, register offsets and strobe timing.
 * assumes a 50 MHz system clock and an 8-bit flash data path.
 */
`ifndef FECS_CONSTS_SVH
`define FECS_CONSTS_SVH

`define FECS_CMD_READ_STATUS 8'h70
`define FECS_CMD_ERASE_SETUP 8'h20
`define FECS_CMD_CHIP_SETUP 8'h30
`define FECS_CMD_CONFIRM 8'hD0
`define FECS_CMD_READ_ARRAY 8'hFF
`define FECS_CMD_CLEAR_STATUS 8'h50

`define FECS_SR_READY 7
`define FECS_SR_ERASE_ERR 5
`define FECS_SR_PROG_ERR 4
`define FECS_SR_PROTECT 1

`define FECS_REG_CTRL 8'h00
`define FECS_REG_ADDR 8'h04
`define FECS_REG_STATUS 8'h08
`define FECS_REG_IRQ_STAT 8'h0C
`define FECS_REG_IRQ_MASK 8'h10

`define FECS_CTRL_START 0
`define FECS_CTRL_DEFER 3
`define FECS_IRQ_DONE 0
`define FECS_IRQ_ERR 1

`define FECS_CLK_NS 20
`define FECS_T_STROBE_NS 60
`define FECS_STROBE_CYC ((`FECS_T_STROBE_NS + `FECS_CLK_NS - 1) / `FECS_CLK_NS)

`endif

/* File: hdl/fecs_pkg.sv */
/*
 * types of the flash erase command sequencer.
 * does not include fecs_consts.svh; the state, op and result encodings are numbered here.
 */
`default_nettype none
package fecs_pkg;

    typedef enum logic [3:0] {
        S_IDLE = 4'b0000,
        S_PRE_CMD = 4'b0001,
        S_PRE_READ = 4'b0010,
        S_SETUP = 4'b0011,
        S_CONFIRM = 4'b0100,
        S_POST_READ = 4'b0101,
        S_CHECK = 4'b0110,
        S_SIMPLE = 4'b0111
    } fecs_state_e;

    typedef enum logic [1:0] {
        OP_BLOCK = 2'b00,
        OP_CHIP = 2'b01,
        OP_CLEAR = 2'b10,
        OP_ARRAY = 2'b11
    } fecs_op_e;

    typedef enum logic [1:0] {
        RES_OK = 2'b00,
        RES_PROTECT = 2'b01,
        RES_SEQ = 2'b10,
        RES_ERASE = 2'b11
    } fecs_res_e;

endpackage

`default_nettype wire

/* File: hdl/fecs_host.sv */
/*
 * host-side erase sequencer for a parallel flash: software orders block
 * erase, chip erase, status clear or read-array over classic wishbone; the
 * block drives the flash pins and polls its status byte.
 * assumes flash pins synchronous to clk_i and an 8-bit flash data bus.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fecs_consts.svh"

module fecs_host #(
    parameter int FA_W = 22
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    output logic [FA_W-1:0] flash_addr_o,
    input wire logic [7:0] flash_dq_i,
    output logic [7:0] flash_dq_o,
    output logic flash_dq_oe_o,
    output logic flash_ce_n_o,
    output logic flash_we_n_o,
    output logic flash_oe_n_o
);

    localparam logic [3:0] STB = 4'(`FECS_STROBE_CYC);

    fecs_pkg::fecs_state_e state_r, state_nxt;
    fecs_pkg::fecs_op_e op_r, op_nxt;
    fecs_pkg::fecs_res_e res_r, res_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] sr_r, sr_nxt;
    logic [FA_W-1:0] blk_r, blk_nxt;
    logic defer_r, defer_nxt;
    logic [1:0] ist_r, ist_nxt;
    logic [1:0] imask_r, imask_nxt;
    logic ack_nxt, irq_nxt;
    logic [31:0] rdat_nxt;
    logic [FA_W-1:0] fa_nxt;
    logic [7:0] fdq_nxt;
    logic foe_nxt, ce_n_nxt, we_n_nxt, oe_n_nxt;

    logic wb_req, wb_wr, go, bus_st, bus_wr, strobe_on, sample, phase_end;
    logic done_ev, err_ev;
    logic [7:0] bus_data;
    logic [FA_W-1:0] bus_addr;
    logic [31:0] wmask, ctrl_w;
    logic [1:0] ist_clr;

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr = wb_req && wb_we_i;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign ctrl_w = wb_dat_i & wmask;
    // start while busy is dropped: one sequence at a time
    assign go = wb_wr && wb_adr_i == `FECS_REG_CTRL && ctrl_w[`FECS_CTRL_START]
        && state_r == fecs_pkg::S_IDLE;
    assign strobe_on = cnt_r >= 4'h1 && cnt_r <= STB;
    assign sample = cnt_r == STB + 4'h1;
    assign phase_end = cnt_r == STB + 4'h2;

    // what each bus state puts on the flash pins
    always_comb
    begin
        bus_st = 1'b1;
        bus_wr = 1'b1;
        bus_data = 8'h00;
        bus_addr = '0;
        case (state_r)
            fecs_pkg::S_PRE_CMD: bus_data = `FECS_CMD_READ_STATUS;
            fecs_pkg::S_PRE_READ: bus_wr = 1'b0;
            fecs_pkg::S_POST_READ: bus_wr = 1'b0;
            fecs_pkg::S_SETUP:
            begin
                bus_data = (op_r == fecs_pkg::OP_CHIP) ? `FECS_CMD_CHIP_SETUP
                    : `FECS_CMD_ERASE_SETUP;
            end
            fecs_pkg::S_CONFIRM:
            begin
                bus_data = `FECS_CMD_CONFIRM;
                // chip erase confirm may go anywhere; zero keeps it simple
                bus_addr = (op_r == fecs_pkg::OP_CHIP) ? '0 : blk_r;
            end
            fecs_pkg::S_SIMPLE:
            begin
                bus_data = (op_r == fecs_pkg::OP_ARRAY) ? `FECS_CMD_READ_ARRAY
                    : `FECS_CMD_CLEAR_STATUS;
            end
            default: bus_st = 1'b0;
        endcase
    end

    // sequencer
    always_comb
    begin
        state_nxt = state_r;
        op_nxt = op_r;
        res_nxt = res_r;
        sr_nxt = sr_r;
        cnt_nxt = bus_st ? (phase_end ? 4'h0 : cnt_r + 4'h1) : 4'h0;
        done_ev = 1'b0;
        err_ev = 1'b0;
        if (bus_st && sample && !bus_wr)
            sr_nxt = flash_dq_i;
        case (state_r)
            fecs_pkg::S_IDLE:
            begin
                if (go)
                begin
                    op_nxt = fecs_pkg::fecs_op_e'(ctrl_w[2:1]);
                    state_nxt = (ctrl_w[2] == 1'b1) ? fecs_pkg::S_SIMPLE : fecs_pkg::S_PRE_CMD;
                end
            end
            fecs_pkg::S_PRE_CMD:
                if (phase_end)
                    state_nxt = fecs_pkg::S_PRE_READ;
            fecs_pkg::S_PRE_READ:
                // busy means read again; no timeout, software may reset
                if (phase_end && sr_r[`FECS_SR_READY])
                    state_nxt = fecs_pkg::S_SETUP;
            fecs_pkg::S_SETUP:
                if (phase_end)
                    state_nxt = fecs_pkg::S_CONFIRM;
            fecs_pkg::S_CONFIRM:
                if (phase_end)
                    state_nxt = fecs_pkg::S_POST_READ;
            fecs_pkg::S_POST_READ:
                if (phase_end && sr_r[`FECS_SR_READY])
                    state_nxt = fecs_pkg::S_CHECK;
            fecs_pkg::S_CHECK:
            begin
                state_nxt = fecs_pkg::S_IDLE;
                done_ev = 1'b1;
                if (defer_r)
                    res_nxt = fecs_pkg::RES_OK;
                else if (sr_r[`FECS_SR_PROTECT])
                    res_nxt = fecs_pkg::RES_PROTECT;
                else if (sr_r[`FECS_SR_PROG_ERR] && sr_r[`FECS_SR_ERASE_ERR])
                    res_nxt = fecs_pkg::RES_SEQ;
                else if (sr_r[`FECS_SR_ERASE_ERR])
                    res_nxt = fecs_pkg::RES_ERASE;
                else
                    res_nxt = fecs_pkg::RES_OK;
                err_ev = res_nxt != fecs_pkg::RES_OK;
            end
            fecs_pkg::S_SIMPLE:
            begin
                if (phase_end)
                begin
                    state_nxt = fecs_pkg::S_IDLE;
                    done_ev = 1'b1;
                end
            end
            default: state_nxt = fecs_pkg::S_IDLE;
        endcase
        // pins lag the state by one flop; address leads the strobe by a cycle
        fa_nxt = bus_addr;
        fdq_nxt = bus_data;
        foe_nxt = bus_st && bus_wr;
        ce_n_nxt = !(bus_st && strobe_on);
        we_n_nxt = !(bus_st && strobe_on && bus_wr);
        oe_n_nxt = !(bus_st && strobe_on && !bus_wr);
    end

    // register file
    always_comb
    begin
        blk_nxt = blk_r;
        defer_nxt = defer_r;
        imask_nxt = imask_r;
        ist_clr = 2'b00;
        rdat_nxt = 32'h0000_0000;
        ack_nxt = wb_req;
        if (wb_wr)
        begin
            case (wb_adr_i)
                `FECS_REG_CTRL:
                    if (wb_sel_i[0])
                        defer_nxt = wb_dat_i[`FECS_CTRL_DEFER];
                `FECS_REG_ADDR: blk_nxt = FA_W'((32'(blk_r) & ~wmask) | ctrl_w);
                `FECS_REG_IRQ_STAT: ist_clr = ctrl_w[1:0];
                `FECS_REG_IRQ_MASK:
                    if (wb_sel_i[0])
                        imask_nxt = wb_dat_i[1:0];
                default: ist_clr = 2'b00;
            endcase
        end
        else if (wb_req)
        begin
            case (wb_adr_i)
                `FECS_REG_CTRL: rdat_nxt = {28'h000_0000, defer_r, op_r, 1'b0};
                `FECS_REG_ADDR: rdat_nxt = 32'(blk_r);
                `FECS_REG_STATUS:
                begin
                    rdat_nxt = {16'h0000, sr_r, 5'h00, res_r,
                        state_r != fecs_pkg::S_IDLE};
                end
                `FECS_REG_IRQ_STAT: rdat_nxt = {30'h0000_0000, ist_r};
                `FECS_REG_IRQ_MASK: rdat_nxt = {30'h0000_0000, imask_r};
                default: rdat_nxt = 32'h0000_0000;
            endcase
        end
        // a new event beats a clear in the same cycle
        ist_nxt = (ist_r & ~ist_clr) | {err_ev, done_ev};
        irq_nxt = |(ist_nxt & imask_nxt);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r <= fecs_pkg::S_IDLE;
            op_r <= fecs_pkg::OP_BLOCK;
            res_r <= fecs_pkg::RES_OK;
            cnt_r <= 4'h0;
            sr_r <= 8'h00;
            blk_r <= '0;
            defer_r <= 1'b0;
            ist_r <= 2'b00;
            imask_r <= 2'b00;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            irq_o <= 1'b0;
            flash_addr_o <= '0;
            flash_dq_o <= 8'h00;
            flash_dq_oe_o <= 1'b0;
            flash_ce_n_o <= 1'b1;
            flash_we_n_o <= 1'b1;
            flash_oe_n_o <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            op_r <= op_nxt;
            res_r <= res_nxt;
            cnt_r <= cnt_nxt;
            sr_r <= sr_nxt;
            blk_r <= blk_nxt;
            defer_r <= defer_nxt;
            ist_r <= ist_nxt;
            imask_r <= imask_nxt;
            wb_ack_o <= ack_nxt;
            wb_dat_o <= rdat_nxt;
            irq_o <= irq_nxt;
            flash_addr_o <= fa_nxt;
            flash_dq_o <= fdq_nxt;
            flash_dq_oe_o <= foe_nxt;
            flash_ce_n_o <= ce_n_nxt;
            flash_we_n_o <= we_n_nxt;
            flash_oe_n_o <= oe_n_nxt;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_status_cmd_out: assert property (
        (state_r == fecs_pkg::S_PRE_CMD && cnt_r == 4'h2) |->
        !flash_we_n_o && flash_dq_oe_o && flash_dq_o == 8'h70 && flash_addr_o == '0)
        else $error("read-status byte not driven");
    a_ready_gates_setup: assert property (
        (state_r == fecs_pkg::S_PRE_READ ##1 state_r == fecs_pkg::S_SETUP) |->
        $past(sr_r[7]))
        else $error("setup issued while flash busy");
    a_setup_byte: assert property (
        (state_r == fecs_pkg::S_SETUP && cnt_r == 4'h2) |->
        !flash_we_n_o && flash_dq_o == ((op_r == fecs_pkg::OP_CHIP) ? 8'h30 : 8'h20))
        else $error("wrong erase setup byte");
    a_confirm_addr: assert property (
        (state_r == fecs_pkg::S_CONFIRM && cnt_r == 4'h2) |-> !flash_we_n_o
        && flash_dq_o == 8'hD0
        && flash_addr_o == ((op_r == fecs_pkg::OP_CHIP) ? '0 : blk_r))
        else $error("wrong confirm byte or address");
    a_wait_ready: assert property (
        (state_r == fecs_pkg::S_POST_READ ##1 state_r == fecs_pkg::S_CHECK) |->
        sr_r[7] ##1 state_r == fecs_pkg::S_IDLE)
        else $error("erase finished before ready");
    a_array_byte: assert property (
        (state_r == fecs_pkg::S_SIMPLE && op_r == fecs_pkg::OP_ARRAY && cnt_r == 4'h2)
        |-> !flash_we_n_o && flash_dq_o == 8'hFF)
        else $error("read-array byte not driven");
    a_seq_err: assert property (
        (state_r == fecs_pkg::S_CHECK && !defer_r && !sr_r[1] && sr_r[4] && sr_r[5])
        |=> res_r == fecs_pkg::RES_SEQ ##1 ist_r[1])
        else $error("sequence error not reported");
    a_erase_err: assert property (
        (state_r == fecs_pkg::S_CHECK && !defer_r && sr_r[5:4] == 2'b10 && !sr_r[1])
        |=> res_r == fecs_pkg::RES_ERASE)
        else $error("erase error not reported");
    a_protect_first: assert property (
        (state_r == fecs_pkg::S_CHECK && !defer_r && sr_r[1]) |=>
        res_r == fecs_pkg::RES_PROTECT)
        else $error("protect not reported first");
    a_clear_byte: assert property (
        (state_r == fecs_pkg::S_SIMPLE && op_r == fecs_pkg::OP_CLEAR && cnt_r == 4'h2)
        |-> !flash_we_n_o && flash_dq_o == 8'h50)
        else $error("clear-status byte not driven");
    a_strobe_width: assert property (
        $fell(flash_ce_n_o) |-> !flash_ce_n_o [*3] ##1 flash_ce_n_o)
        else $error("strobe width wrong");
    a_read_bus_free: assert property (
        !flash_oe_n_o |-> !flash_dq_oe_o && flash_we_n_o)
        else $error("data bus driven during read");

    c_block_erase: cover property (
        state_r == fecs_pkg::S_CHECK && op_r == fecs_pkg::OP_BLOCK);
    c_chip_erase: cover property (
        state_r == fecs_pkg::S_CHECK && op_r == fecs_pkg::OP_CHIP);
    c_busy_poll: cover property (
        state_r == fecs_pkg::S_POST_READ && phase_end && !sr_r[7]);
    c_irq_raised: cover property ($rose(irq_o));

endmodule

`default_nettype wire

/* File: verification/fecs_flash_model.sv */
/*
 * behavioural model of the parallel flash behind the erase sequencer:
 * command decode, status byte, busy timing and injected error outcomes.
 * assumes pins driven synchronously to clk_i; writes latch on we_n rising.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fecs_consts.svh"

module fecs_flash_model #(
    parameter int FA_W = 22
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [FA_W-1:0] addr_i,
    input wire logic [7:0] dq_i,
    output logic [7:0] dq_o,
    input wire logic ce_n_i,
    input wire logic we_n_i,
    input wire logic oe_n_i,
    input wire logic [1:0] err_mode_i,
    input wire logic [7:0] busy_cyc_i,
    output logic [7:0] sr_o,
    output logic [FA_W-1:0] conf_addr_o,
    output logic [7:0] setup_o,
    output logic [7:0] early_o,
    output logic stat_mode_o
);
    logic we_q;
    logic pend;
    logic drive;
    logic [7:0] cnt;
    logic [7:0] last;
    logic [7:0] fail;

    assign drive = !ce_n_i && !oe_n_i;
    // released bus shows the inverse of its last byte, so stale data never matches
    assign dq_o = drive ? (stat_mode_o ? sr_o : addr_i[7:0] ^ 8'h5a) : ~last;
    // protect also raises erase error, so a wrong check order is visible
    assign fail = (err_mode_i == 2'h1) ? 8'h22 : (err_mode_i == 2'h2) ? 8'h30 :
        (err_mode_i == 2'h3) ? 8'h20 : 8'h00;

    always @(posedge clk_i)
    begin
        we_q <= we_n_i;
        if (drive)
            last <= dq_o;
        if (rst_i)
        begin
            sr_o <= 8'h80;
            pend <= 1'b0;
            cnt <= 8'h00;
            stat_mode_o <= 1'b0;
            early_o <= 8'h00;
            setup_o <= 8'h00;
            conf_addr_o <= '0;
        end
        else
        begin
            if (cnt != 8'h00)
                cnt <= cnt - 8'h01;
            if (cnt == 8'h01)
                sr_o <= sr_o | fail | 8'h80;
            if (we_n_i && !we_q)
            begin
                if (pend)
                begin
                    pend <= 1'b0;
                    if (dq_i == `FECS_CMD_CONFIRM)
                    begin
                        sr_o[7] <= 1'b0;
                        cnt <= busy_cyc_i;
                        conf_addr_o <= addr_i;
                    end
                    else
                        sr_o[5:4] <= 2'b11;
                end
                else if (dq_i == `FECS_CMD_ERASE_SETUP || dq_i == `FECS_CMD_CHIP_SETUP)
                begin
                    pend <= 1'b1;
                    setup_o <= dq_i;
                    stat_mode_o <= 1'b1;
                    if (!sr_o[7])
                        early_o <= early_o + 8'h01;
                end
                else if (dq_i == `FECS_CMD_READ_STATUS)
                    stat_mode_o <= 1'b1;
                else if (dq_i == `FECS_CMD_CLEAR_STATUS)
                    sr_o <= sr_o & 8'hcd;
                else if (dq_i == `FECS_CMD_READ_ARRAY)
                    stat_mode_o <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

/* File: verification/fecs_host_tb.sv */
/*
 * self-checking bench of the erase sequencer: random erase orders over
 * wishbone against the flash model, with error injection and irq checks.
 * assumes fecs_host, fecs_flash_model and fecs_consts.svh compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fecs_consts.svh"

module fecs_host_tb;
    localparam int FA_W = 22;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0000_0000;
    logic [3:0] wb_sel = 4'h0;
    logic wb_we = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic [31:0] wb_rd;
    logic wb_ack;
    logic irq;
    logic [FA_W-1:0] fa;
    logic [FA_W-1:0] conf;
    logic [7:0] fdo;
    logic [7:0] fdi;
    logic foe;
    logic fce_n;
    logic fwe_n;
    logic foe_n;
    logic [1:0] err_mode = 2'h0;
    logic [7:0] busy_cyc = 8'h01;
    logic [7:0] sr;
    logic [7:0] setup;
    logic [7:0] early;
    logic smode;
    integer seed = 32'hb784_01ac;
    int err_count = 0;
    int check_count = 0;

    initial forever #10 clk_i = ~clk_i;

    fecs_host #(.FA_W(FA_W)) fecs_host_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr),
        .wb_dat_i(wb_dat), .wb_sel_i(wb_sel), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack), .irq_o(irq),
        .flash_addr_o(fa), .flash_dq_i(fdi), .flash_dq_o(fdo), .flash_dq_oe_o(foe),
        .flash_ce_n_o(fce_n), .flash_we_n_o(fwe_n), .flash_oe_n_o(foe_n));

    fecs_flash_model #(.FA_W(FA_W)) fecs_flash_model_inst (.clk_i(clk_i), .rst_i(rst_i),
        .addr_i(fa), .dq_i(fdo), .dq_o(fdi), .ce_n_i(fce_n), .we_n_i(fwe_n), .oe_n_i(foe_n),
        .err_mode_i(err_mode), .busy_cyc_i(busy_cyc), .sr_o(sr), .conf_addr_o(conf),
        .setup_o(setup), .early_o(early), .stat_mode_o(smode));

    function automatic logic [7:0] bits_of(input logic [1:0] m);
        return (m == 2'h1) ? 8'h22 : (m == 2'h2) ? 8'h30 : (m == 2'h3) ? 8'h20 : 8'h00;
    endfunction

    // protect first, then both error bits, then erase error alone
    function automatic logic [1:0] res_of(input logic [7:0] b);
        return b[1] ? 2'h1 : (b[5:4] == 2'b11) ? 2'h2 : b[5] ? 2'h3 : 2'h0;
    endfunction

    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            $display("wrong value %s expected %h seen %h", name, e, g);
            err_count++;
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat <= d;
        wb_sel <= 4'hf;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack !== 1'b1 && n < 50);
        q = wb_rd;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        if (n >= 50)
        begin
            err_count++;
            stop_test();
        end
    endtask

    // bounded poll of the busy bit; a flash stuck busy ends the run
    task automatic run_op(input logic [31:0] ctrl, input logic dup, output logic [31:0] st);
        int n;
        wb(1'b1, `FECS_REG_CTRL, ctrl, st);
        // a second start while busy must be dropped
        if (dup)
            wb(1'b1, `FECS_REG_CTRL, ctrl ^ 32'h0000_0002, st);
        n = 0;
        do
        begin
            wb(1'b0, `FECS_REG_STATUS, 32'h0000_0000, st);
            n++;
        end
        while (st[0] !== 1'b0 && n < 1000);
        if (n >= 1000)
        begin
            err_count++;
            stop_test();
        end
    endtask

    initial
    begin
        logic [31:0] q;
        logic [FA_W-1:0] a;
        logic [7:0] errs;
        logic [1:0] m;
        logic [1:0] mask;
        logic [1:0] exp_irq;
        logic op;
        logic defer;
        errs = 8'h00;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, `FECS_REG_STATUS, 32'h0000_0000, q);
        chk("status after reset", 32'h0000_0000, q);
        wb(1'b1, 8'h14, 32'hffff_ffff, q);
        wb(1'b0, 8'h14, 32'h0000_0000, q);
        chk("unmapped read", 32'h0000_0000, q);
        wb(1'b1, `FECS_REG_ADDR, 32'hffff_ffff, q);
        wb(1'b0, `FECS_REG_ADDR, 32'h0000_0000, q);
        chk("addr width", 32'h003f_ffff, q);
        for (int i = 0; i < 14; i++)
        begin
            m = (i < 4) ? i[1:0] : 2'($random(seed));
            op = (i < 4) ? i[0] : 1'($random(seed));
            defer = (i == 5);
            a = FA_W'($random(seed));
            mask = 2'($random(seed));
            err_mode <= m;
            busy_cyc <= 8'h01 + 8'($random(seed) & 31);
            wb(1'b1, `FECS_REG_ADDR, 32'(a), q);
            wb(1'b1, `FECS_REG_IRQ_STAT, 32'h0000_0003, q);
            wb(1'b1, `FECS_REG_IRQ_MASK, 32'(mask), q);
            run_op({28'h000_0000, defer, 1'b0, op, 1'b1}, i == 6 || i == 11, q);
            errs = errs | bits_of(m);
            chk("result", defer ? 2'h0 : res_of(errs), q[2:1]);
            chk("flash status", 8'h80 | errs, q[15:8]);
            chk("confirm addr", op ? '0 : a, 32'(conf));
            chk("setup byte", op ? 8'h30 : 8'h20, 32'(setup));
            exp_irq = {!defer && res_of(errs) != 2'h0, 1'b1};
            wb(1'b0, `FECS_REG_IRQ_STAT, 32'h0000_0000, q);
            chk("irq stat", 32'(exp_irq), q);
            chk("irq level", 32'(|(exp_irq & mask)), 32'(irq));
            wb(1'b0, `FECS_REG_CTRL, 32'h0000_0000, q);
            chk("ctrl read", {28'h000_0000, defer, 1'b0, op, 1'b0}, q);
            if (i < 4 || i == 9 || ($random(seed) & 3) == 0)
            begin
                run_op(32'h0000_0005, 1'b0, q);
                errs = 8'h00;
                chk("flash cleared", 8'h80, 32'(sr));
            end
        end
        chk("erase before ready", 8'h00, 32'(early));
        // reset in mid-erase: the sequencer and the pins must go idle
        wb(1'b1, `FECS_REG_CTRL, 32'h0000_0001, q);
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, `FECS_REG_STATUS, 32'h0000_0000, q);
        chk("status after mid reset", 32'h0000_0000, q);
        chk("pins after mid reset", 32'h0000_0007, 32'({fce_n, fwe_n, foe_n}));
        wb(1'b1, `FECS_REG_IRQ_MASK, 32'h0000_0001, q);
        run_op(32'h0000_0007, 1'b0, q);
        chk("array mode", 1'b0, 32'(smode));
        wb(1'b0, `FECS_REG_IRQ_STAT, 32'h0000_0000, q);
        chk("irq on array", 1'b1, 32'(irq));
        wb(1'b1, `FECS_REG_IRQ_STAT, 32'h0000_0003, q);
        wb(1'b0, `FECS_REG_IRQ_STAT, 32'h0000_0000, q);
        chk("irq stat cleared", 32'h0000_0000, q);
        chk("irq cleared", 1'b0, 32'(irq));
        stop_test();
    end
endmodule

`default_nettype wire
